// ===== inc/dop_pkg.sv
// package for the accelerator operation and observation register bank
//
// Summary of operation
// - operation word holds a right-shift amount field, values zero to 32.
// - shift amount applies only to arithmetic ops carrying the shift option.
// - shift source bit picks field low five bits or shared word low five.
// - rounding bit set enables auto-rounding of shifted results.
// - clamp field: none, unsigned 8, signed 16, adaptive to stored size.
// - condition field tests data status: always, >=0, !=0, >0, <=0, ==0, <0, never.
// - read-only flag shows condition outcome: zero true, one false.
// - writing the program counter clears the whole operation word.
// - in debug mode, fetching the break address stops execution.
// - two low break address bits are read-only and read as zero.
// - after a stop, fetched-instruction register shows the next instruction.
// - X and Y last pointer registers catch the latest read addresses.
// - Z last pointer register catches the latest written address.
// - X and Y read-word registers catch the latest read data.
// - Z written-word register catches the latest written data.
// - accumulator width is a build parameter, default 72 bits.
// - host reads accumulator as three 32-bit slices, low to high.
// - version word is read-only and fixed at build time.
// - a loop count whose low eight bits are zero makes the repeat instruction a no-op.
package dop_pkg;
    // *************************************************************
    // register offsets (byte addresses)
    // *************************************************************
    localparam logic [7:0] DOP_PC_OFS = 8'h00;
    localparam logic [7:0] DOP_LOOPCNT_OFS = 8'h2C;
    localparam logic [7:0] DOP_OPPAR_OFS = 8'h30;
    localparam logic [7:0] DOP_TEMP_OFS = 8'h38;
    localparam logic [7:0] DOP_VER_OFS = 8'h3C;
    localparam logic [7:0] DOP_BRK_OFS = 8'h40;
    localparam logic [7:0] DOP_IFR_OFS = 8'h44;
    localparam logic [7:0] DOP_XPTR_OFS = 8'h48;
    localparam logic [7:0] DOP_YPTR_OFS = 8'h4C;
    localparam logic [7:0] DOP_ZPTR_OFS = 8'h50;
    localparam logic [7:0] DOP_XDAT_OFS = 8'h54;
    localparam logic [7:0] DOP_YDAT_OFS = 8'h58;
    localparam logic [7:0] DOP_ZDAT_OFS = 8'h5C;
    localparam logic [7:0] DOP_ACC0_OFS = 8'h60;
    localparam logic [7:0] DOP_ACC1_OFS = 8'h64;
    localparam logic [7:0] DOP_ACC2_OFS = 8'h68;
    localparam logic [7:0] DOP_DBG_OFS = 8'h6C;
    // *************************************************************
    // field positions and reset values
    // *************************************************************
    localparam int DOP_SRC_BIT = 6;
    localparam int DOP_RND_BIT = 7;
    localparam int DOP_CLAMP_LSB = 8;
    localparam int DOP_COND_LSB = 16;
    localparam int DOP_FLAG_BIT = 19;
    localparam logic [5:0] DOP_SHIFT_MAX = 6'h20;
    localparam logic [31:0] DOP_ZERO_RST = 32'h0000_0000;
    localparam logic [31:0] DOP_SEG_RST = 32'h0000_0000;
    localparam logic [31:0] DOP_OPPAR_WMASK = 32'h0007_03FF;
    localparam logic [31:0] DOP_BRK_WMASK = 32'hFFFF_FFFC;
    // version word value is arbitrary
    localparam logic [31:0] DOP_VERSION = 32'h0001_0000;
    localparam int DOP_ACC_W = 72;
    // *************************************************************
    // types
    // *************************************************************
    typedef struct packed {
        logic [5:0] shift_amount_field;
        logic shift_src;
        logic rounding_on;
        logic [1:0] clamp_mode;
        logic [2:0] condition_code;
    } dop_oppar_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dop_bus_t;
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [31:0] data;
    } dop_xfer_t;
    typedef enum logic [2:0] {
        DOP_RUN = 3'b001,
        DOP_DEBUG = 3'b010,
        DOP_STOP = 3'b100
    } dop_state_t;
endpackage

// ===== src/dop_regs.sv
// operation parameter and observation register bank of the accelerator
`timescale 1ns/100ps
module dop_regs
    import dop_pkg::*;
#(
    parameter int ACC_W = DOP_ACC_W,
    parameter logic [31:0] VERSION = DOP_VERSION
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire dop_bus_t bus,
    output logic [31:0] rdata,
    input wire logic [31:0] shared_pointer_word,
    input wire logic status_neg,
    input wire logic status_zero,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic [31:0] fetch_code,
    input wire logic halt_seen,
    input wire logic resume,
    input wire dop_xfer_t x_rd,
    input wire dop_xfer_t y_rd,
    input wire dop_xfer_t z_wr,
    input wire logic [ACC_W-1:0] accumulator,
    input wire logic loop_is_repeat,
    input wire logic cond_wr_req,
    output logic [4:0] shift_eff,
    output logic shift_use,
    output logic round_use,
    output logic [1:0] clamp_mode,
    output logic cond_exec_flag,
    output logic cond_wr_en,
    output logic loop_skip,
    output logic halted,
    output logic [31:0] pc
);
    // ***********************************************************
    // decode
    // ***********************************************************
    dop_oppar_t opp_q;
    dop_state_t st_q;
    logic [31:0] temp_q, brk_q, ifr_q, dbg_q, loopcnt_q;
    dop_xfer_t xl_q, yl_q, zl_q;
    logic pc_wr, opp_wr, cond_true;
    logic [95:0] acc_wide;

    assign pc_wr = bus.wr && bus.addr == DOP_PC_OFS;
    assign opp_wr = bus.wr && bus.addr == DOP_OPPAR_OFS;
    assign acc_wide = 96'(accumulator);

    // condition test on data status
    always_comb
    begin
        case (opp_q.condition_code)
            3'h0: cond_true = 1'b1;
            3'h1: cond_true = !status_neg;
            3'h2: cond_true = !status_zero;
            3'h3: cond_true = !status_neg && !status_zero;
            3'h4: cond_true = status_neg || status_zero;
            3'h5: cond_true = status_zero;
            3'h6: cond_true = status_neg;
            default: cond_true = 1'b0;
        endcase
    end
    assign cond_exec_flag = !cond_true;
    assign cond_wr_en = cond_wr_req && cond_true;

    // shift amount source, only for ops with the shift option
    assign shift_eff = opp_q.shift_src ? shared_pointer_word[4:0]
        : opp_q.shift_amount_field[4:0];
    // amount 32 uses bit 5, so field width is kept at six bits
    assign shift_use = opp_q.shift_amount_field == DOP_SHIFT_MAX;
    assign round_use = opp_q.rounding_on;
    assign clamp_mode = opp_q.clamp_mode;
    assign loop_skip = loop_is_repeat && loopcnt_q[7:0] == 8'h00;
    assign halted = st_q == DOP_STOP;

    // ***********************************************************
    // host-writable registers
    // ***********************************************************
    // operation word; a pc write wins and clears it
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            opp_q <= '0;
        else if (pc_wr)
            opp_q <= '0;
        else if (opp_wr)
        begin
            opp_q.shift_amount_field <= bus.wdata[5:0] > DOP_SHIFT_MAX
                ? DOP_SHIFT_MAX : bus.wdata[5:0];
            opp_q.shift_src <= bus.wdata[DOP_SRC_BIT];
            opp_q.rounding_on <= bus.wdata[DOP_RND_BIT];
            opp_q.clamp_mode <= bus.wdata[DOP_CLAMP_LSB +: 2];
            opp_q.condition_code <= bus.wdata[DOP_COND_LSB +: 3];
        end
    end

    // plain writable words
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            temp_q <= DOP_ZERO_RST;
            brk_q <= DOP_SEG_RST;
            dbg_q <= DOP_ZERO_RST;
            loopcnt_q <= DOP_ZERO_RST;
            pc <= DOP_ZERO_RST;
        end
        else if (bus.wr)
        begin
            if (bus.addr == DOP_TEMP_OFS)
                temp_q <= bus.wdata;
            else if (bus.addr == DOP_BRK_OFS)
                brk_q <= bus.wdata & DOP_BRK_WMASK;
            else if (bus.addr == DOP_DBG_OFS)
                dbg_q <= {31'h0, bus.wdata[0]};
            else if (bus.addr == DOP_LOOPCNT_OFS)
                loopcnt_q <= {16'h0, bus.wdata[15:0]};
            else if (bus.addr == DOP_PC_OFS)
                pc <= bus.wdata;
        end
    end

    // ***********************************************************
    // debug stop control
    // ***********************************************************
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_q <= DOP_RUN;
        else
            case (st_q)
                DOP_RUN:
                    if (halt_seen)
                        st_q <= DOP_STOP;
                    else if (dbg_q[0])
                        st_q <= DOP_DEBUG;
                DOP_DEBUG:
                    if (halt_seen || (fetch_valid && fetch_addr == brk_q))
                        st_q <= DOP_STOP;
                    else if (!dbg_q[0])
                        st_q <= DOP_RUN;
                DOP_STOP:
                    if (resume)
                        st_q <= dbg_q[0] ? DOP_DEBUG : DOP_RUN;
                default: st_q <= DOP_RUN;
            endcase
    end

    // fetched code frozen while stopped, so it names the next one
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            ifr_q <= DOP_ZERO_RST;
        else if (fetch_valid && st_q != DOP_STOP)
            ifr_q <= fetch_code;
    end

    // ***********************************************************
    // bus observation captures
    // ***********************************************************
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            xl_q <= '0;
            yl_q <= '0;
            zl_q <= '0;
        end
        else
        begin
            if (x_rd.valid)
                xl_q <= x_rd;
            if (y_rd.valid)
                yl_q <= y_rd;
            if (z_wr.valid)
                zl_q <= z_wr;
        end
    end

    // ***********************************************************
    // read port, data one cycle after the strobe
    // ***********************************************************
    // read-only offsets have no write path at all
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata <= DOP_ZERO_RST;
        else if (!bus.rd)
            rdata <= DOP_ZERO_RST;
        else if (bus.addr == DOP_OPPAR_OFS)
            rdata <= {12'h0, cond_exec_flag, opp_q.condition_code, 6'h0,
                opp_q.clamp_mode, opp_q.rounding_on, opp_q.shift_src,
                opp_q.shift_amount_field};
        else if (bus.addr == DOP_TEMP_OFS)
            rdata <= temp_q;
        else if (bus.addr == DOP_VER_OFS)
            rdata <= VERSION;
        else if (bus.addr == DOP_BRK_OFS)
            rdata <= {brk_q[31:2], 2'b00};
        else if (bus.addr == DOP_IFR_OFS)
            rdata <= ifr_q;
        else if (bus.addr == DOP_XPTR_OFS)
            rdata <= xl_q.addr;
        else if (bus.addr == DOP_YPTR_OFS)
            rdata <= yl_q.addr;
        else if (bus.addr == DOP_ZPTR_OFS)
            rdata <= zl_q.addr;
        else if (bus.addr == DOP_XDAT_OFS)
            rdata <= xl_q.data;
        else if (bus.addr == DOP_YDAT_OFS)
            rdata <= yl_q.data;
        else if (bus.addr == DOP_ZDAT_OFS)
            rdata <= zl_q.data;
        else if (bus.addr == DOP_ACC0_OFS)
            rdata <= acc_wide[31:0];
        else if (bus.addr == DOP_ACC1_OFS)
            rdata <= acc_wide[63:32];
        else if (bus.addr == DOP_ACC2_OFS)
            rdata <= acc_wide[95:64];
        else if (bus.addr == DOP_DBG_OFS)
            rdata <= {29'h0, st_q == DOP_STOP, st_q == DOP_DEBUG, dbg_q[0]};
        else if (bus.addr == DOP_LOOPCNT_OFS)
            rdata <= loopcnt_q;
        else if (bus.addr == DOP_PC_OFS)
            rdata <= pc;
        else
            rdata <= DOP_ZERO_RST;
    end
endmodule

// ===== dv/dop_host.sv
// host bus model that drives register reads and writes
`timescale 1ns/100ps
module dop_host
    import dop_pkg::*;
(
    input wire logic sys_clk,
    output dop_bus_t bus,
    input wire logic [31:0] rdata
);
    // bus stays idle until the bench asks for a cycle
    initial bus = '0;
    // one-cycle write strobe, released on the following edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        bus <= '0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge sys_clk);
        bus <= '0;
        // take the word mid-cycle; it drops to zero on the next edge
        @(negedge sys_clk);
        d = rdata;
    endtask
endmodule

// ===== dv/dop_regs_props.sv
// port checks of the operation register bank
`timescale 1ns/100ps
module dop_regs_props
    import dop_pkg::*;
#(
    parameter int ACC_W = DOP_ACC_W,
    parameter logic [31:0] VERSION = DOP_VERSION
)
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire dop_bus_t bus,
    input wire logic [31:0] rdata,
    input wire logic [31:0] shared_pointer_word,
    input wire logic [ACC_W-1:0] accumulator,
    input wire logic loop_is_repeat,
    input wire logic cond_wr_req,
    input wire logic [4:0] shift_eff,
    input wire logic round_use,
    input wire logic [1:0] clamp_mode,
    input wire logic cond_exec_flag,
    input wire logic cond_wr_en,
    input wire logic loop_skip
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // host write strobe decoded once, reused by two checks
    wire op_wr = bus.wr && bus.addr == DOP_OPPAR_OFS;
    a_ver_read: assert property (bus.rd && bus.addr == DOP_VER_OFS |=>
        rdata == VERSION) else $error("version word wrong");
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data not idle");
    a_brk_low: assert property (bus.rd && bus.addr == DOP_BRK_OFS |=>
        rdata[1:0] == 2'h0) else $error("break low bits set");
    a_acc_mid: assert property (bus.rd && bus.addr == DOP_ACC1_OFS |=>
        rdata == $past(accumulator[63:32])) else $error("acc slice wrong");
    a_pc_clear: assert property (bus.wr && bus.addr == DOP_PC_OFS |=>
        !cond_exec_flag && !round_use && clamp_mode == 2'h0
        && shift_eff == 5'h00) else $error("pc write kept fields");
    a_op_fields: assert property (op_wr |=>
        round_use == $past(bus.wdata[7])
        && clamp_mode == $past(bus.wdata[9:8])) else $error("fields");
    a_shift_src: assert property (op_wr && !bus.wdata[5] |=>
        shift_eff == ($past(bus.wdata[6]) ? shared_pointer_word[4:0]
        : $past(bus.wdata[4:0]))) else $error("shift source wrong");
    a_wr_gate: assert property (cond_wr_en ==
        (cond_wr_req && !cond_exec_flag)) else $error("write gate wrong");
    a_skip_rep: assert property (loop_skip |-> loop_is_repeat)
        else $error("skip without repeat");
    c_pc: cover property (bus.wr && bus.addr == DOP_PC_OFS);
    c_gate: cover property (cond_wr_req && !cond_wr_en);
    c_skip: cover property (loop_skip);
endmodule
bind dop_regs dop_regs_props #(.ACC_W(ACC_W), .VERSION(VERSION)) u_props
    (.sys_clk, .arst_n, .bus, .rdata, .shared_pointer_word, .accumulator,
    .loop_is_repeat, .cond_wr_req, .shift_eff, .round_use, .clamp_mode,
    .cond_exec_flag, .cond_wr_en, .loop_skip);

// ===== dv/dsp_accel_operation_regs_tb.sv
// self-checking bench of the operation register bank
`timescale 1ns/100ps
module dsp_accel_operation_regs_tb
    import dop_pkg::*;
;
    logic sys_clk = 0, arst_n = 0, status_neg = 0, status_zero = 0;
    logic fetch_valid = 0, halt_seen = 0, resume = 0, loop_is_repeat = 0;
    logic cond_wr_req = 0, shift_use, round_use, cond_exec_flag;
    logic cond_wr_en, loop_skip, halted;
    logic [31:0] shared_pointer_word = 0, fetch_addr = 0, fetch_code = 0;
    logic [31:0] rdata, pc, d, r, e, av[3], dv[3];
    logic [4:0] shift_eff;
    logic [1:0] clamp_mode;
    logic [71:0] accumulator = 0;
    dop_xfer_t x_rd = '0, y_rd = '0, z_wr = '0;
    dop_bus_t bus;
    int miscompares = 0, comparisons = 0, cycles = 0;
    dop_regs #(.ACC_W(72)) uut (.*);
    dop_host host (.sys_clk, .bus, .rdata);
    // free-running clock, 40 ns period
    initial forever #20 sys_clk = ~sys_clk;
    // hang guard: far above the few hundred cycles the run needs
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            miscompares++;
            stop_test();
        end
    end
    // condition false: 1 means execution disabled
    function automatic logic cf(input logic [2:0] c);
        logic [7:0] t;
        t = {1'b0, status_neg, status_zero, status_neg || status_zero,
            !status_neg && !status_zero, !status_zero, !status_neg, 1'b1};
        return !t[c];
    endfunction
    // expected readback: read-only bits dropped, shift capped at 32
    function automatic logic [31:0] op_exp(input logic [31:0] w);
        logic [31:0] e;
        e = w & DOP_OPPAR_WMASK;
        if (e[5:0] > DOP_SHIFT_MAX)
            e[5:0] = DOP_SHIFT_MAX;
        e[DOP_FLAG_BIT] = cf(e[18:16]);
        return e;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************************
    // main sequence
    // ****************************************************
    initial
    begin
        void'($urandom(26));
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        host.rd(DOP_OPPAR_OFS, d);
        chk(d, 32'h0000_0000);
        host.wr(DOP_VER_OFS, $urandom);
        host.rd(DOP_VER_OFS, d);
        chk(d, DOP_VERSION);
        host.rd(8'hF0, d);
        chk(d, 32'h0000_0000);
        r = $urandom;
        host.wr(DOP_TEMP_OFS, r);
        host.rd(DOP_TEMP_OFS, d);
        chk(d, r);
        r = $urandom;
        host.wr(DOP_BRK_OFS, r);
        host.rd(DOP_BRK_OFS, d);
        chk(d, r & DOP_BRK_WMASK);
        // every condition code against negative, zero and positive data
        for (int c = 0; c < 24; c++)
        begin
            host.wr(DOP_OPPAR_OFS, {13'h0, 3'(c / 3), 16'h0});
            status_neg <= c % 3 == 1;
            status_zero <= c % 3 == 2;
            cond_wr_req <= 1'b1;
            @(negedge sys_clk);
            chk(cond_exec_flag, cf(3'(c / 3)));
            chk(cond_wr_en, !cf(3'(c / 3)));
        end
        // random operation words, with the shift bounds first
        for (int i = 0; i < 20; i++)
        begin
            r = i == 0 ? 32'h0000_0020 : i == 1 ? 32'h0000_003F : $urandom;
            shared_pointer_word <= $urandom;
            host.wr(DOP_OPPAR_OFS, r);
            host.rd(DOP_OPPAR_OFS, d);
            chk(d, op_exp(r));
            e = op_exp(r);
            chk(shift_eff, r[6] ? shared_pointer_word[4:0] : e[4:0]);
            chk(shift_use, e[5:0] == DOP_SHIFT_MAX);
        end
        r = $urandom;
        host.wr(DOP_PC_OFS, r);
        host.rd(DOP_OPPAR_OFS, d);
        chk(d, 32'h0000_0000);
        chk(pc, r);
        host.rd(DOP_PC_OFS, d);
        chk(d, r);
        // bus captures, twice so the latest transfer must win
        repeat (2)
        begin
            foreach (av[k])
            begin
                av[k] = $urandom;
                dv[k] = $urandom;
            end
            @(posedge sys_clk);
            x_rd <= '{1'b1, av[0], dv[0]};
            y_rd <= '{1'b1, av[1], dv[1]};
            z_wr <= '{1'b1, av[2], dv[2]};
            accumulator <= {8'($urandom), $urandom, $urandom};
            @(posedge sys_clk);
            x_rd <= '0;
            y_rd <= '0;
            z_wr <= '0;
        end
        for (int k = 0; k < 3; k++)
        begin
            host.rd(DOP_XPTR_OFS + 8'(4 * k), d);
            chk(d, av[k]);
            host.rd(DOP_XDAT_OFS + 8'(4 * k), d);
            chk(d, dv[k]);
        end
        host.rd(DOP_ACC0_OFS, d);
        chk(d, accumulator[31:0]);
        host.rd(DOP_ACC2_OFS, d);
        chk(d, {24'h0, accumulator[71:64]});
        // zero low loop count with a nonzero upper count still skips
        loop_is_repeat <= 1'b1;
        host.wr(DOP_LOOPCNT_OFS, 32'h0000_0100);
        @(negedge sys_clk);
        chk(loop_skip, 1'b1);
        host.wr(DOP_LOOPCNT_OFS, 32'h0000_0001);
        @(negedge sys_clk);
        chk(loop_skip, 1'b0);
        // break on a fetch in debug mode, then resume
        r = $urandom & DOP_BRK_WMASK;
        host.wr(DOP_DBG_OFS, 32'h0000_0001);
        host.wr(DOP_BRK_OFS, r);
        @(posedge sys_clk);
        fetch_valid <= 1'b1;
        fetch_addr <= r;
        fetch_code <= $urandom;
        @(posedge sys_clk);
        fetch_valid <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(halted, 1'b1);
        host.rd(DOP_IFR_OFS, d);
        chk(d, fetch_code);
        resume <= 1'b1;
        @(posedge sys_clk);
        resume <= 1'b0;
        @(negedge sys_clk);
        chk(halted, 1'b0);
        // halt instruction stops the run as well
        @(posedge sys_clk);
        halt_seen <= 1'b1;
        @(posedge sys_clk);
        halt_seen <= 1'b0;
        @(negedge sys_clk);
        chk(halted, 1'b1);
        stop_test();
    end
endmodule
